/* design/pcc_pkg.sv */
// Purpose: Shared constants for the port counter clear and overflow block.
// Assumes: 26 switch ports, one core clock, plain register port.
// Notes:   Register indexes are word indexes on the register port.
package pcc_pkg;
    // ****************************************************************
    // Register map, reset values and port count.
    // ****************************************************************
    localparam int          NUM_PORTS      = 26;
    localparam logic [7:0]  OFF_COL_OVF    = 8'h13;
    localparam logic [7:0]  OFF_RENEW      = 8'h14;
    localparam logic [7:0]  OFF_IRQ_MASK   = 8'h40;
    localparam int          RENEW_BUSY_BIT = 26;
    localparam logic [25:0] COL_OVF_RST    = 26'h0000000;
    localparam logic [25:0] RENEW_RST      = 26'h0000000;
    localparam logic [25:0] IRQ_MASK_RST   = 26'h0000000;
    localparam logic [4:0]  PORT_LAST      = 5'h19;
    typedef enum logic [1:0] {PCC_IDLE, PCC_CLEAR, PCC_DONE} pcc_state_t;
endpackage

/* design/pcc_top.sv */
// Purpose: Collision overflow flags and per-port counter renew sequencer.
// Assumes: Host strobes are one cycle, synchronous to sys_clk.
// Notes:   Counter clear walks the ports one per cycle.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - 26 collision overflow flags, one per port
// - Flag holds until CPU read clears it
// - Flags and renew register reset to zero
// - Mask bit n clears port n counters
// - Counter access blocked while renew busy
// - Busy clears after the walk over all 26 ports, whatever the mask selects
module pcc_top
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Counter side
    input  wire logic [25:0] col_ovf_evt,
    output logic      [25:0] cnt_clear,
    output logic             cnt_access_block,
    // Interrupt
    output logic             irq
);

    // ****************************************************************
    // Registered state.
    // ****************************************************************
    typedef struct packed {
        pcc_pkg::pcc_state_t state;
        logic [25:0]         col_ovf;
        logic [25:0]         mask;
        logic [25:0]         irq_mask;
        logic [4:0]          port;
        logic                busy;
        logic [25:0]         clr;
        logic                block;
        logic                irq;
        logic [31:0]         rdata;
    } pcc_regs_t;

    pcc_regs_t s_reg;
    pcc_regs_t s_next;
    logic      start_ok;

    assign reg_rdata        = s_reg.rdata;
    assign cnt_clear        = s_reg.clr;
    assign cnt_access_block = s_reg.block;
    assign irq              = s_reg.irq;

    // A renew write while busy is dropped, not queued, so software must poll first.
    // Start gate
    assign start_ok = reg_wr && (reg_addr == pcc_pkg::OFF_RENEW)
                      && reg_wdata[pcc_pkg::RENEW_BUSY_BIT] && !s_reg.busy;

    // ****************************************************************
    // Next state.
    // ****************************************************************
    always_comb
    begin
        s_next       = s_reg;
        s_next.clr   = 26'h0000000;
        s_next.rdata = 32'h00000000;
        if (reg_rd && reg_addr == pcc_pkg::OFF_COL_OVF)
        begin
            s_next.col_ovf = col_ovf_evt;
        end
        else
        begin
            s_next.col_ovf = s_reg.col_ovf | col_ovf_evt;
        end
        if (reg_wr && reg_addr == pcc_pkg::OFF_IRQ_MASK)
        begin
            s_next.irq_mask = reg_wdata[25:0];
        end
        if (reg_rd)
        begin
            unique case (reg_addr)
                pcc_pkg::OFF_COL_OVF:  s_next.rdata = {6'h00, s_reg.col_ovf};
                pcc_pkg::OFF_RENEW:    s_next.rdata = {5'h00, s_reg.busy, s_reg.mask};
                pcc_pkg::OFF_IRQ_MASK: s_next.rdata = {6'h00, s_reg.irq_mask};
                default:               s_next.rdata = 32'h00000000;
            endcase
        end
        unique case (s_reg.state)
            pcc_pkg::PCC_IDLE:
            begin
                if (start_ok)
                begin
                    s_next.mask  = reg_wdata[25:0];
                    s_next.busy  = 1'b1;
                    s_next.block = 1'b1;
                    s_next.port  = 5'h00;
                    s_next.state = pcc_pkg::PCC_CLEAR;
                end
            end
            pcc_pkg::PCC_CLEAR:
            begin
                s_next.clr[s_reg.port] = s_reg.mask[s_reg.port];
                s_next.port = s_reg.port + 5'h01;
                if (s_reg.port == pcc_pkg::PORT_LAST)
                begin
                    s_next.state = pcc_pkg::PCC_DONE;
                end
            end
            pcc_pkg::PCC_DONE:
            begin
                s_next.busy  = 1'b0;
                s_next.block = 1'b0;
                s_next.state = pcc_pkg::PCC_IDLE;
            end
            default: s_next.state = pcc_pkg::PCC_IDLE;
        endcase
        s_next.irq = |(s_next.col_ovf & s_next.irq_mask);
    end

    // ****************************************************************
    // State register.
    // ****************************************************************
    // Reset values
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            s_reg          <= '0;
            s_reg.state    <= pcc_pkg::PCC_IDLE;
            s_reg.col_ovf  <= pcc_pkg::COL_OVF_RST;
            s_reg.mask     <= pcc_pkg::RENEW_RST;
            s_reg.irq_mask <= pcc_pkg::IRQ_MASK_RST;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    // Block follows busy
    property p_block_busy;
        @(posedge sys_clk) disable iff (!rst_b)
        cnt_access_block == s_reg.busy;
    endproperty
    a_block_busy: assert property (p_block_busy) else $error("block differs from busy");

    property p_busy_ends;
        @(posedge sys_clk) disable iff (!rst_b)
        $rose(s_reg.busy) |-> ##27 !s_reg.busy;
    endproperty
    a_busy_ends: assert property (p_busy_ends) else $error("busy not released");

    sequence s_start;
        start_ok;
    endsequence
    property p_start;
        @(posedge sys_clk) disable iff (!rst_b)
        s_start |=> s_reg.busy && s_reg.mask == $past(reg_wdata[25:0]);
    endproperty
    a_start: assert property (p_start) else $error("renew not started");

    property p_ignore;
        @(posedge sys_clk) disable iff (!rst_b)
        (reg_wr && reg_addr == pcc_pkg::OFF_RENEW && s_reg.busy) |=> $stable(s_reg.mask);
    endproperty
    a_ignore: assert property (p_ignore) else $error("mask changed while busy");

    property p_nobusy;
        @(posedge sys_clk) disable iff (!rst_b)
        (reg_wr && reg_addr == pcc_pkg::OFF_RENEW
         && !reg_wdata[pcc_pkg::RENEW_BUSY_BIT] && !s_reg.busy)
        |=> !s_reg.busy;
    endproperty
    a_nobusy: assert property (p_nobusy) else $error("renew without busy bit");

    property p_sticky;
        @(posedge sys_clk) disable iff (!rst_b)
        (col_ovf_evt[0]) |=> s_reg.col_ovf[0];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag not set");

    property p_rdclr;
        @(posedge sys_clk) disable iff (!rst_b)
        (reg_rd && reg_addr == pcc_pkg::OFF_COL_OVF && col_ovf_evt == 26'h0000000)
        |=> s_reg.col_ovf == 26'h0000000;
    endproperty
    a_rdclr: assert property (p_rdclr) else $error("flag not cleared by read");

    property p_hold;
        @(posedge sys_clk) disable iff (!rst_b)
        (!(reg_rd && reg_addr == pcc_pkg::OFF_COL_OVF))
        |=> (s_reg.col_ovf & $past(s_reg.col_ovf)) == $past(s_reg.col_ovf);
    endproperty
    a_hold: assert property (p_hold) else $error("flag lost");

    property p_clr_idle;
        @(posedge sys_clk) disable iff (!rst_b)
        !s_reg.busy |-> cnt_clear == 26'h0000000;
    endproperty
    a_clr_idle: assert property (p_clr_idle) else $error("clear while idle");

    property p_busy_read;
        @(posedge sys_clk) disable iff (!rst_b)
        (reg_rd && reg_addr == pcc_pkg::OFF_RENEW)
        |=> reg_rdata[pcc_pkg::RENEW_BUSY_BIT] == $past(s_reg.busy);
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("busy bit misread");

    property p_flag_read;
        @(posedge sys_clk) disable iff (!rst_b)
        (reg_rd && reg_addr == pcc_pkg::OFF_COL_OVF)
        |=> reg_rdata == {6'h00, $past(s_reg.col_ovf)};
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("flag readback");

    // Zero after reset
    // Not gated by reset on purpose, since it must look at the reset cycles.
    property p_reset_zero;
        @(posedge sys_clk)
        !rst_b |=> s_reg.col_ovf == pcc_pkg::COL_OVF_RST
                   && s_reg.mask == pcc_pkg::RENEW_RST
                   && !s_reg.busy && !cnt_access_block
                   && cnt_clear == 26'h0000000 && !irq;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("not zero after reset");

    sequence s_busy_hold;
        s_reg.busy ##26 s_reg.busy;
    endsequence
    sequence s_busy_drop;
        !s_reg.busy;
    endsequence
    property p_busy_span;
        @(posedge sys_clk) disable iff (!rst_b)
        $rose(s_reg.busy) |-> s_busy_hold ##1 s_busy_drop;
    endproperty
    a_busy_span: assert property (p_busy_span) else $error("busy span wrong");

    property p_block_start;
        @(posedge sys_clk) disable iff (!rst_b)
        s_start |=> cnt_access_block;
    endproperty
    a_block_start: assert property (p_block_start) else $error("block late");

    property p_nomask_write;
        @(posedge sys_clk) disable iff (!rst_b)
        (reg_wr && reg_addr == pcc_pkg::OFF_RENEW && !reg_wdata[pcc_pkg::RENEW_BUSY_BIT])
        |=> $stable(s_reg.mask);
    endproperty
    a_nomask_write: assert property (p_nomask_write) else $error("mask latched");

    property p_irq_level;
        @(posedge sys_clk) disable iff (!rst_b)
        irq == |(s_reg.col_ovf & s_reg.irq_mask);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq mismatch");

    // ****************************************************************
    // Per-port checks.
    // ****************************************************************
    for (genvar i = 0; i < pcc_pkg::NUM_PORTS; i++)
    begin : g_port
        property p_flag_set;
            @(posedge sys_clk) disable iff (!rst_b)
            col_ovf_evt[i] |=> s_reg.col_ovf[i];
        endproperty
        a_flag_set: assert property (p_flag_set) else $error("flag not set");

        property p_clr_sel;
            @(posedge sys_clk) disable iff (!rst_b)
            cnt_clear[i] |-> s_reg.busy && s_reg.mask[i];
        endproperty
        a_clr_sel: assert property (p_clr_sel) else $error("stray clear");
    end

endmodule

`default_nettype wire

/* dv/pcc_host.sv */
// Purpose: Host CPU model for the register port.
// Assumes: One strobe per access, driven after a rising edge.
// Notes:   A gap cycle sits between accesses to keep drives race free.
`timescale 1ns/10ps
`default_nettype none
module pcc_host
(
    // Clock
    input  wire logic        sys_clk,
    // Register port
    output logic      [7:0]  reg_addr,
    output logic      [31:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [31:0] reg_rdata
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // ****************************************************************
    // Register access.
    // ****************************************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
    begin
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    end
    endtask
    // Data is taken mid-cycle, once the registered answer has settled.
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
    begin
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        v = reg_rdata;
    end
    endtask
endmodule
`default_nettype wire

/* dv/test_port_counter_clear_overflow.sv */
// Purpose: Self-checking bench for flags, renew and interrupt.
// Assumes: Host model drives the register port.
// Notes:   Clear pulses are gathered into one mask for comparison.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) \
    begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("Error %s exp %0h got %0h", nm, e, g); end end
module test_port_counter_clear_overflow;
    logic        sys_clk;
    logic        rst_b;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [25:0] col_ovf_evt;
    logic [25:0] cnt_clear;
    logic        cnt_access_block;
    logic        irq;
    logic [25:0] seen;
    logic [31:0] d;
    logic [7:0]  adr [4] = '{8'h13, 8'h14, 8'h40, 8'h20};
    int          fails;
    int          comparisons;
    int          n;
    pcc_top i_dut (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .col_ovf_evt, .cnt_clear, .cnt_access_block, .irq);
    pcc_host i_host (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    // ****************************************************************
    // Clock and clear pulse collector.
    // ****************************************************************
    initial sys_clk = 1'b0;
    always #10 sys_clk = ~sys_clk;
    // Cleared in reset so that unknown outputs before the first edge do not stick.
    always @(posedge sys_clk)
    begin
        if (!rst_b)
            seen <= 26'h0000000;
        else
            seen <= seen | cnt_clear;
    end
    task automatic close_out;
    begin
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    // ****************************************************************
    // Test sequence.
    // ****************************************************************
    initial
    begin
        rst_b = 1'b0;
        col_ovf_evt = 26'h0000000;
        fails = 0;
        comparisons = 0;
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (n = 0; n < 4; n++)
        begin
            i_host.rd(adr[n], d);
            `CHK("reset value", 32'h00000000, d)
        end
        $display("test reset done");
        i_host.wr(pcc_pkg::OFF_IRQ_MASK, 32'h00000001);
        i_host.rd(pcc_pkg::OFF_IRQ_MASK, d);
        `CHK("irq mask", 32'h00000001, d)
        @(posedge sys_clk);
        col_ovf_evt <= 26'h2000001;
        @(posedge sys_clk);
        col_ovf_evt <= 26'h0000000;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK("irq", 1'b1, irq)
        i_host.rd(pcc_pkg::OFF_COL_OVF, d);
        `CHK("flags", 32'h02000001, d)
        // An event in the cycle of the clearing read must survive that read.
        fork
            i_host.rd(pcc_pkg::OFF_COL_OVF, d);
            begin
                @(posedge sys_clk);
                col_ovf_evt <= 26'h0000008;
                @(posedge sys_clk);
                col_ovf_evt <= 26'h0000000;
            end
        join
        `CHK("flags read", 32'h00000000, d)
        `CHK("irq off", 1'b0, irq)
        i_host.rd(pcc_pkg::OFF_COL_OVF, d);
        `CHK("set wins", 32'h00000008, d)
        $display("test flags done");
        i_host.wr(pcc_pkg::OFF_RENEW, 32'h000000F0);
        i_host.rd(pcc_pkg::OFF_RENEW, d);
        `CHK("renew idle", 32'h00000000, d)
        `CHK("no clear", 26'h0000000, seen)
        i_host.wr(pcc_pkg::OFF_RENEW, 32'h0400000F);
        @(negedge sys_clk);
        `CHK("block", 1'b1, cnt_access_block)
        i_host.wr(pcc_pkg::OFF_RENEW, 32'h04000030);
        i_host.rd(pcc_pkg::OFF_RENEW, d);
        `CHK("busy", 32'h0400000F, d)
        for (n = 0; n < 20 && d[26] !== 1'b0; n++)
            i_host.rd(pcc_pkg::OFF_RENEW, d);
        `CHK("renew done", 32'h0000000F, d)
        `CHK("cleared", 26'h000000F, seen)
        `CHK("unblock", 1'b0, cnt_access_block)
        $display("test renew done");
        @(posedge sys_clk);
        col_ovf_evt <= 26'h0000010;
        @(posedge sys_clk);
        col_ovf_evt <= 26'h0000000;
        i_host.wr(pcc_pkg::OFF_RENEW, 32'h04000001);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        i_host.rd(pcc_pkg::OFF_COL_OVF, d);
        `CHK("flags after reset", 32'h00000000, d)
        i_host.rd(pcc_pkg::OFF_RENEW, d);
        `CHK("renew after reset", 32'h00000000, d)
        i_host.rd(pcc_pkg::OFF_IRQ_MASK, d);
        `CHK("mask after reset", 32'h00000000, d)
        `CHK("block after reset", 1'b0, cnt_access_block)
        `CHK("irq after reset", 1'b0, irq)
        `CHK("no clear after reset", 26'h0000000, seen)
        $display("test mid-run reset done");
        close_out();
    end
endmodule
`default_nettype wire
